// ==== verilog/sbs_sram.sv ====
// Synchronous burst SRAM core with registered inputs and burst counter
`timescale 1ns/100ps
module sbs_sram
    import sbs_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int FD = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              reset_n,
    // Synchronous controls
    input  wire logic [AW-1:0]     word_addr,
    input  wire logic              chip_en_n,
    input  wire logic              proc_addr_strobe_n,
    input  wire logic              ctrl_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              high_byte_wr_n,
    input  wire logic              low_byte_wr_n,
    // Asynchronous output enable
    input  wire logic              out_en_n,
    // Data pins split into in, out, enable (enable low drives)
    input  wire logic [15:0]       data_io_in,
    output logic      [15:0]       data_io_out,
    output logic                   data_io_oe_n,
    input  wire logic              low_parity_io_in,
    output logic                   low_parity_io_out,
    output logic                   low_parity_io_oe_n,
    input  wire logic              high_parity_io_in,
    output logic                   high_parity_io_out,
    output logic                   high_parity_io_oe_n,
    // Write path status
    output logic                   wr_ready
);
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    logic [AW-1:0]     base_r;
    logic [1:0]        cnt_r;
    sbs_state_type     state_r;
    logic              rd_act_r;
    logic              wr_pend_r;

    // Event decode from sampled pins; chip enable only with strobes
    wire any_wr_n  = low_byte_wr_n & high_byte_wr_n;
    wire desel     = !ctrl_addr_strobe_n && chip_en_n;
    wire load_p    = !proc_addr_strobe_n && !chip_en_n && !desel;
    wire load_c    = !ctrl_addr_strobe_n && proc_addr_strobe_n && !chip_en_n;
    wire load_any  = load_p || load_c;
    wire ign_p     = !proc_addr_strobe_n && chip_en_n && ctrl_addr_strobe_n;
    wire cont      = proc_addr_strobe_n && ctrl_addr_strobe_n;
    wire step      = cont && !burst_advance_n;
    wire active    = (state_r == SBS_ACTIVE);
    wire do_wr     = active && cont && !any_wr_n || load_c && !any_wr_n;

    function automatic logic [1:0] nxt_cnt(input logic [1:0] c);
        nxt_cnt = c + 2'h1;
    endfunction : nxt_cnt

    wire [1:0]    cnt_nxt  = load_any ? CNT_RESET : (active && step) ? nxt_cnt(cnt_r) : cnt_r;
    wire [AW-1:0] base_nxt = load_any ? word_addr : base_r;
    // Low pair interleaves as start XOR count
    wire [AW-1:0] eff_addr = {base_nxt[AW-1:BURST_W], base_nxt[1:0] ^ cnt_nxt};

    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            base_r   <= '0;
            cnt_r    <= CNT_RESET;
            state_r  <= SBS_IDLE;
            rd_act_r <= 1'b0;
        end
        else
        begin
            base_r   <= base_nxt;
            cnt_r    <= cnt_nxt;
            if (desel)
                state_r <= SBS_DESEL;
            else if (load_any)
                state_r <= SBS_ACTIVE;
            rd_act_r <= !desel && (load_p || (load_any || active && cont) && any_wr_n) && !ign_p;
        end
    end

    // Write words queue ahead of the array; completion is self-timed
    localparam int FW = AW + WORD_W + 2;
    logic [AW-1:0]     addr_q_r;
    logic [WORD_W-1:0] din_r;
    logic [1:0]        lane_r;
    logic              wf_valid;
    logic              wf_ready;
    logic [FW-1:0]     wf_data;
    wire  [FW-1:0]     wq_in = {addr_q_r, lane_r, din_r};

    always_ff @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            addr_q_r  <= '0;
            din_r     <= '0;
            lane_r    <= 2'h0;
            wr_pend_r <= 1'b0;
        end
        else
        begin
            wr_pend_r <= do_wr;
            addr_q_r  <= eff_addr;
            din_r     <= {high_parity_io_in, data_io_in[15:8], low_parity_io_in, data_io_in[7:0]};
            lane_r    <= {!high_byte_wr_n, !low_byte_wr_n};
        end
    end

    sbs_fifo #(.WIDTH(FW), .DEPTH(FD)) u_wq
    (
        .mclk      (mclk),
        .rst_n     (rst_n_r),
        .in_valid  (wr_pend_r),
        .in_ready  (wr_ready),
        .in_data   (wq_in),
        .out_valid (wf_valid),
        .out_ready (wf_ready),
        .out_data  (wf_data)
    );
    assign wf_ready = 1'b1;

    wire [AW-1:0]     wa = wf_data[FW-1 -: AW];
    wire [1:0]        wl = wf_data[WORD_W +: 2];
    wire [WORD_W-1:0] wd = wf_data[WORD_W-1:0];

    // Flow-through read of the registered address
    wire [AW-1:0]      rd_addr = {base_r[AW-1:BURST_W], base_r[1:0] ^ cnt_r};
    logic [WORD_W-1:0] rd_word;

    // One array per lane so each lane has a single writer
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            logic [LANE_W-1:0] lane_mem_r [DEPTH];
            always_ff @(posedge mclk)
            begin
                if (wf_valid && wl[g])
                    lane_mem_r[wa] <= wd[g*LANE_W +: LANE_W];
            end
            assign rd_word[g*LANE_W +: LANE_W] = lane_mem_r[rd_addr];
        end
    endgenerate

    wire              drive   = rd_act_r && !out_en_n && low_byte_wr_n && high_byte_wr_n;

    assign data_io_out         = {rd_word[HIGH_LSB +: 8], rd_word[LOW_LSB +: 8]};
    assign low_parity_io_out   = rd_word[8];
    assign high_parity_io_out  = rd_word[17];
    assign data_io_oe_n        = !drive;
    assign low_parity_io_oe_n  = !drive;
    assign high_parity_io_oe_n = !drive;

    a_desel_off: assert property (@(posedge mclk) disable iff (!rst_n_r)
        desel |=> data_io_oe_n) else $error("drivers on after deselect");
    a_oe_gate: assert property (@(posedge mclk) disable iff (!rst_n_r)
        out_en_n |-> data_io_oe_n) else $error("drive with oe high");
    a_wr_off: assert property (@(posedge mclk) disable iff (!rst_n_r)
        !(low_byte_wr_n && high_byte_wr_n) |-> data_io_oe_n) else $error("drive in write");
    a_load_cnt: assert property (@(posedge mclk) disable iff (!rst_n_r)
        load_any |=> cnt_r == CNT_RESET) else $error("counter not cleared");
    a_step_cnt: assert property (@(posedge mclk) disable iff (!rst_n_r)
        active && step && !load_any && !desel |=> cnt_r == $past(cnt_r) + 2'h1)
        else $error("burst did not step");
    a_hold_cnt: assert property (@(posedge mclk) disable iff (!rst_n_r)
        active && cont && burst_advance_n |=> $stable(cnt_r)) else $error("suspend moved");
    a_padsp_rd: assert property (@(posedge mclk) disable iff (!rst_n_r)
        load_p |=> !wr_pend_r) else $error("write on processor strobe");
    a_ce_ignore: assert property (@(posedge mclk) disable iff (!rst_n_r)
        active && step |=> base_r == $past(base_r)) else $error("base changed in burst");
    a_wrap4: assert property (@(posedge mclk) disable iff (!rst_n_r)
        active && step && cnt_r == 2'h3 && !load_any |=> cnt_r == CNT_RESET)
        else $error("no wrap");
    a_reset_off: assert property (@(posedge mclk)
        !rst_n_r |-> data_io_oe_n) else $error("drive during reset");
endmodule : sbs_sram

// ==== verilog/sbs_pkg.sv ====
// Constants for the synchronous burst SRAM port
package sbs_pkg;
    localparam int ADDR_W     = 16;
    localparam int LANE_W     = 9;
    localparam int WORD_W     = 18;
    localparam int DEPTH      = 65536;
    localparam int LOW_LSB    = 0;
    localparam int HIGH_LSB   = 9;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 8;
    localparam logic [1:0] CNT_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        SBS_IDLE   = 2'b00,
        SBS_ACTIVE = 2'b01,
        SBS_DESEL  = 2'b10
    } sbs_state_type;
endpackage : sbs_pkg

// ==== verilog/sbs_fifo.sv ====
// Parameterised valid/ready FIFO for write words
`timescale 1ns/100ps
module sbs_fifo
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_r;
    logic [PW-1:0]    rd_r;
    logic [PW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= wr_r + 1'b1;
            if (pop)
                rd_r <= rd_r + 1'b1;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage carries no reset, it is data only
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_r[wr_r] <= in_data;
    end
endmodule : sbs_fifo

// ==== verif/sbs_host.sv ====
// Host model driving the burst SRAM pins one clock at a time
`timescale 1ns/100ps
module sbs_host
(
    // Clock
    input  wire logic        mclk,
    // Controls toward the SRAM
    output logic [15:0]      word_addr,
    output logic             chip_en_n,
    output logic             proc_addr_strobe_n,
    output logic             ctrl_addr_strobe_n,
    output logic             burst_advance_n,
    output logic             high_byte_wr_n,
    output logic             low_byte_wr_n,
    output logic             out_en_n,
    // Resolved data pins
    output logic [15:0]      data_io_in,
    output logic             low_parity_io_in,
    output logic             high_parity_io_in,
    input  wire logic [15:0] data_io_out,
    input  wire logic        low_parity_io_out,
    input  wire logic        high_parity_io_out,
    input  wire logic        data_io_oe_n,
    input  wire logic        low_parity_io_oe_n,
    input  wire logic        high_parity_io_oe_n
);
    logic [17:0] wr_w = 18'h00000;
    logic [17:0] rd_w;
    logic        rd_on;
    logic        oe_free = 1'b0;
    logic        oe_lvl = 1'b0;
    // Unless oe_free is set, backs off the shared pins on writes to avoid contention
    assign out_en_n = oe_free ? oe_lvl : ~(high_byte_wr_n & low_byte_wr_n);
    assign data_io_in = data_io_oe_n ? {wr_w[16:9], wr_w[7:0]} : data_io_out;
    assign low_parity_io_in = low_parity_io_oe_n ? wr_w[8] : low_parity_io_out;
    assign high_parity_io_in = high_parity_io_oe_n ? wr_w[17] : high_parity_io_out;
    initial
    begin
        {word_addr, chip_en_n, proc_addr_strobe_n, ctrl_addr_strobe_n} = {16'h0000, 3'h7};
        {burst_advance_n, high_byte_wr_n, low_byte_wr_n} = 3'h7;
    end
    // Entered one step after an edge; leaves at the same phase a cycle later
    task automatic step(input logic [15:0] a, input logic [3:0] c, input logic [1:0] we,
                        input logic [17:0] d);
        word_addr = a;
        {chip_en_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = c;
        {high_byte_wr_n, low_byte_wr_n} = we;
        // Idle bus toggles so a stale word is never mistaken for read data
        wr_w = (&we) ? ~wr_w : d;
        @(posedge mclk);
        #0.5;
        rd_w = {high_parity_io_out, data_io_out[15:8], low_parity_io_out, data_io_out[7:0]};
        rd_on = ~(data_io_oe_n | low_parity_io_oe_n | high_parity_io_oe_n);
        #0.5;
    endtask : step
endmodule : sbs_host

// ==== verif/sync_burst_sram_port_tb.sv ====
// Self-checking bench for the burst SRAM port
`timescale 1ns/100ps
module sync_burst_sram_port_tb;
    localparam logic [3:0] PLOAD = 4'h3, CLOAD = 4'h5, CONT = 4'hE;
    localparam logic [3:0] SUSP = 4'h7, DESEL = 4'hD, PIDLE = 4'hB;
    logic        mclk, reset_n, wr_ready, out_en_n, data_io_oe_n;
    logic [15:0] word_addr, data_io_in, data_io_out;
    logic        chip_en_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    logic        high_byte_wr_n, low_byte_wr_n, low_parity_io_in, low_parity_io_out;
    logic        low_parity_io_oe_n, high_parity_io_in, high_parity_io_out, high_parity_io_oe_n;
    int          bad_count = 0;
    int          checks = 0;
    sbs_sram sbs_sram_i (.mclk(mclk), .reset_n(reset_n), .word_addr(word_addr),
        .chip_en_n(chip_en_n), .proc_addr_strobe_n(proc_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
        .high_byte_wr_n(high_byte_wr_n), .low_byte_wr_n(low_byte_wr_n), .out_en_n(out_en_n),
        .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n),
        .low_parity_io_in(low_parity_io_in), .low_parity_io_out(low_parity_io_out),
        .low_parity_io_oe_n(low_parity_io_oe_n), .high_parity_io_in(high_parity_io_in),
        .high_parity_io_out(high_parity_io_out), .high_parity_io_oe_n(high_parity_io_oe_n),
        .wr_ready(wr_ready));
    sbs_host sbs_host_i (.mclk(mclk), .word_addr(word_addr), .chip_en_n(chip_en_n),
        .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
        .burst_advance_n(burst_advance_n), .high_byte_wr_n(high_byte_wr_n),
        .low_byte_wr_n(low_byte_wr_n), .out_en_n(out_en_n), .data_io_in(data_io_in),
        .low_parity_io_in(low_parity_io_in), .high_parity_io_in(high_parity_io_in),
        .data_io_out(data_io_out), .low_parity_io_out(low_parity_io_out),
        .high_parity_io_out(high_parity_io_out), .data_io_oe_n(data_io_oe_n),
        .low_parity_io_oe_n(low_parity_io_oe_n), .high_parity_io_oe_n(high_parity_io_oe_n));
    function automatic logic [17:0] pat(input logic [15:0] a);
        return {a[8:0] ^ 9'h0A5, a[8:0]};
    endfunction : pat
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic t_burst();
        logic [15:0] b;
        b = 16'h1235;
        sbs_host_i.step(b, CLOAD, 2'h0, pat(b));
        // Address pins carry junk during the burst; chip enable is high too
        for (int i = 1; i < 4; i++)
            sbs_host_i.step(~b, CONT, 2'h0, pat(b ^ 16'(i)));
        check("wr_ready", 18'(wr_ready), 18'h00001);
        sbs_host_i.step(b, SUSP, 2'h3, 18'h00000);
        sbs_host_i.step(b, PLOAD, 2'h3, 18'h00000);
        check("burst first", sbs_host_i.rd_w, pat(b));
        for (int i = 1; i < 6; i++)
        begin
            sbs_host_i.step(16'hFFFF, CONT, 2'h3, 18'h00000);
            check("burst next", sbs_host_i.rd_w, pat(b ^ 16'(i % 4)));
        end
        $display("test burst done");
    endtask : t_burst
    task automatic t_lane();
        sbs_host_i.step(16'h0402, CLOAD, 2'h0, pat(16'h0402));
        sbs_host_i.oe_free = 1'b1;
        sbs_host_i.step(16'h0402, PLOAD, 2'h0, 18'h3FFFF);
        check("drivers on write", 18'(sbs_host_i.rd_on), 18'h00000);
        sbs_host_i.oe_free = 1'b0;
        sbs_host_i.step(16'h0000, SUSP, 2'h2, 18'h2A5A5);
        repeat (3) sbs_host_i.step(16'h0000, SUSP, 2'h3, 18'h00000);
        check("lane merge", sbs_host_i.rd_w, {9'h0A7, 9'h1A5});
        $display("test lane done");
    endtask : t_lane
    task automatic t_oe();
        sbs_host_i.step(16'h0402, CLOAD, 2'h3, 18'h00000);
        check("ctrl read", sbs_host_i.rd_w, {9'h0A7, 9'h1A5});
        sbs_host_i.oe_free = 1'b1;
        sbs_host_i.oe_lvl = 1'b1;
        sbs_host_i.step(16'h0402, PLOAD, 2'h3, 18'h00000);
        check("oe high", 18'(sbs_host_i.rd_on), 18'h00000);
        sbs_host_i.oe_lvl = 1'b0;
        #10;
        check("oe low", 18'(data_io_oe_n), 18'h00000);
        @(posedge mclk);
        #1;
        sbs_host_i.step(16'h0402, DESEL, 2'h3, 18'h00000);
        check("deselect", 18'(sbs_host_i.rd_on), 18'h00000);
        sbs_host_i.step(16'h0402, CONT, 2'h3, 18'h00000);
        check("idle advance", 18'(sbs_host_i.rd_on), 18'h00000);
        sbs_host_i.step(16'h0402, PIDLE, 2'h3, 18'h00000);
        check("proc with ce high", 18'(sbs_host_i.rd_on), 18'h00000);
        sbs_host_i.oe_free = 1'b0;
        $display("test oe done");
    endtask : t_oe
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial
    begin
        reset_n = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("oe after reset", 18'({data_io_oe_n, low_parity_io_oe_n, high_parity_io_oe_n}),
              18'h00007);
        t_burst();
        t_lane();
        t_oe();
        test_done();
    end
    initial
    begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule : sync_burst_sram_port_tb
